// File: inc/bie_pkg.sv
package bie_pkg;
	localparam logic [3:0] OPC_BIT_SET = 4'h8;
	localparam logic [3:0] OPC_SKIP_CLEAR = 4'hB;
	localparam logic [3:0] OPC_SKIP_SET = 4'hA;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [3:0] ACC_LOW_BANK = 4'h0;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
	localparam logic [2:0] PHASES_PER_CYCLE = 3'h4;
	localparam logic [11:0] RF_ADDR_RST = 12'h000;
	localparam logic [7:0] RF_DATA_RST = 8'h00;

	typedef enum {ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4, ST_NOP} bie_state_t;

	// opcode fields: top nibble, bit index, bank flag, register address
	typedef struct packed {
		logic [3:0] opc;
		logic [2:0] bit_idx;
		logic bank_flag;
		logic [7:0] f;
	} bie_instr_t;

	// request toward the data register file
	typedef struct packed {
		logic [11:0] addr;
		logic rd_en;
		logic wr_en;
		logic [7:0] wdata;
	} bie_rf_req_t;
endpackage

// File: hw/bie_exec.sv
`timescale 1ns/100ps
module bie_exec import bie_pkg::*; (
	input wire logic SYS_CLK, // core clock, 25 MHz
	input wire logic SYS_RST, // synchronous reset, high
	input wire logic CLK_EN, // low freezes all state
	input wire logic INSTR_VALID, // instruction word offered
	input wire bie_instr_t INSTR, // 16-bit opcode
	input wire logic NEXT_TWO_WORD, // prefetched instruction is two words
	input wire logic [3:0] BANK_SEL, // bank_select_reg bank number
	input wire logic EXT_EN, // extended instruction set enabled
	input wire logic [11:0] IDX_BASE, // index base for literal offset mode
	input wire logic [7:0] RF_RDATA, // register file read data
	output bie_rf_req_t RF_REQ, // register file request
	output logic FLUSH, // prefetched instruction discarded
	output logic BUSY, // instruction in progress
	output logic DONE // instruction finished, one pulse
);
	bie_state_t state_reg;
	bie_instr_t instr_reg;
	bie_rf_req_t rf_req_reg;
	logic [7:0] data_reg;
	logic bit_val_reg;
	logic [2:0] nop_cnt_reg;
	logic flush_reg;
	logic busy_reg;
	logic done_reg;
	logic op_known;
	logic skip_next;

	// one-hot mask of the selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction

	// data space address from the bank flag, bank number and offset mode
	function automatic logic [11:0] data_addr(input bie_instr_t ins, input logic [3:0] bank,
			input logic ext, input logic [11:0] base);
		if (ins.bank_flag) begin
			data_addr = {bank, ins.f};
		end else if (ext && ins.f <= IDX_LIMIT) begin
			data_addr = base + {4'h0, ins.f};
		end else if (ins.f <= IDX_LIMIT) begin
			data_addr = {ACC_LOW_BANK, ins.f};
		end else begin
			data_addr = {ACC_HIGH_BANK, ins.f};
		end
	endfunction

	// recognised opcodes and the skip decision
	assign op_known = INSTR.opc == OPC_BIT_SET || INSTR.opc == OPC_SKIP_CLEAR || INSTR.opc == OPC_SKIP_SET;
	assign skip_next = (instr_reg.opc == OPC_SKIP_CLEAR && !bit_val_reg)
		|| (instr_reg.opc == OPC_SKIP_SET && bit_val_reg);

	// phase sequencer: decode, read, process, write, then skip no-ops
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_reg <= ST_IDLE;
		end else if (CLK_EN) begin
			case (state_reg)
				ST_IDLE: begin
					if (INSTR_VALID && op_known) begin
						state_reg <= ST_Q1;
					end
				end
				ST_Q1: state_reg <= ST_Q2;
				ST_Q2: state_reg <= ST_Q3;
				ST_Q3: state_reg <= ST_Q4;
				ST_Q4: state_reg <= skip_next ? ST_NOP : ST_IDLE;
				ST_NOP: begin
					if (nop_cnt_reg == 3'h0) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// instruction latch, taken only while idle
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			instr_reg <= '0;
		end else if (CLK_EN && state_reg == ST_IDLE && INSTR_VALID && op_known) begin
			instr_reg <= INSTR;
		end
	end

	// register file port: address and read in Q2, write in Q4
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			rf_req_reg <= '{addr: RF_ADDR_RST, rd_en: 1'b0, wr_en: 1'b0, wdata: RF_DATA_RST};
		end else if (CLK_EN) begin
			rf_req_reg.rd_en <= 1'b0;
			rf_req_reg.wr_en <= 1'b0;
			if (state_reg == ST_Q1) begin
				rf_req_reg.addr <= data_addr(instr_reg, BANK_SEL, EXT_EN, IDX_BASE);
				rf_req_reg.rd_en <= 1'b1;
			end
			if (state_reg == ST_Q3 && instr_reg.opc == OPC_BIT_SET) begin
				rf_req_reg.wr_en <= 1'b1;
				rf_req_reg.wdata <= data_reg | bit_mask(instr_reg.bit_idx);
			end
		end
	end

	// read data capture and bit test
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			data_reg <= RF_DATA_RST;
			bit_val_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (state_reg == ST_Q2) begin
				data_reg <= RF_RDATA;
			end
			if (state_reg == ST_Q3) begin
				bit_val_reg <= |(data_reg & bit_mask(instr_reg.bit_idx));
			end
		end
	end

	// no-op phase count and discard flag; status flags never touched
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			nop_cnt_reg <= 3'h0;
			flush_reg <= 1'b0;
		end else if (CLK_EN) begin
			if (state_reg == ST_Q4 && skip_next) begin
				flush_reg <= 1'b1;
				nop_cnt_reg <= NEXT_TWO_WORD ? 3'(2 * PHASES_PER_CYCLE - 3'h1)
					: 3'(PHASES_PER_CYCLE - 3'h1);
			end else if (state_reg == ST_NOP) begin
				if (nop_cnt_reg == 3'h0) begin
					flush_reg <= 1'b0;
				end else begin
					nop_cnt_reg <= nop_cnt_reg - 3'h1;
				end
			end
		end
	end

	// busy and done handshake
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (CLK_EN) begin
			done_reg <= (state_reg == ST_Q4 && !skip_next) || (state_reg == ST_NOP && nop_cnt_reg == 3'h0);
			if (state_reg == ST_IDLE && INSTR_VALID && op_known) begin
				busy_reg <= 1'b1;
			end else if ((state_reg == ST_Q4 && !skip_next) || (state_reg == ST_NOP && nop_cnt_reg == 3'h0)) begin
				busy_reg <= 1'b0;
			end
		end
	end

	assign RF_REQ = rf_req_reg;
	assign FLUSH = flush_reg;
	assign BUSY = busy_reg;
	assign DONE = done_reg;

	// checks, counted on enabled edges only
	default clocking cb @(posedge SYS_CLK iff CLK_EN); endclocking
	default disable iff (SYS_RST);

	a_bit_set_write: assert property (
		state_reg == ST_Q3 && instr_reg.opc == OPC_BIT_SET
		|=> rf_req_reg.wr_en && rf_req_reg.wdata == (data_reg | bit_mask(instr_reg.bit_idx)))
		else $error("bit set did not write the set bit");
	a_write_only_set: assert property (
		rf_req_reg.wr_en |-> instr_reg.opc == OPC_BIT_SET && state_reg == ST_Q4)
		else $error("write outside bit set Q4");
	a_access_bank: assert property (
		state_reg == ST_Q1 && !instr_reg.bank_flag && !(EXT_EN && instr_reg.f <= IDX_LIMIT)
		|=> rf_req_reg.addr == {(instr_reg.f <= IDX_LIMIT) ? ACC_LOW_BANK : ACC_HIGH_BANK, instr_reg.f})
		else $error("access bank address wrong");
	a_banked_addr: assert property (
		state_reg == ST_Q1 && instr_reg.bank_flag |=> rf_req_reg.addr == {$past(BANK_SEL), instr_reg.f})
		else $error("banked address wrong");
	a_indexed_addr: assert property (
		state_reg == ST_Q1 && !instr_reg.bank_flag && EXT_EN && instr_reg.f <= IDX_LIMIT
		|=> rf_req_reg.addr == 12'($past(IDX_BASE) + {4'h0, instr_reg.f}))
		else $error("indexed address wrong");
	a_skip_clear: assert property (
		state_reg == ST_Q4 && instr_reg.opc == OPC_SKIP_CLEAR && !bit_val_reg |=> flush_reg && !done_reg)
		else $error("clear test did not skip");
	a_skip_set: assert property (
		state_reg == ST_Q4 && instr_reg.opc == OPC_SKIP_SET && bit_val_reg |=> flush_reg && !done_reg)
		else $error("set test did not skip");
	a_phase_order: assert property (
		state_reg == ST_Q1 |=> state_reg == ST_Q2 ##1 state_reg == ST_Q3 ##1 state_reg == ST_Q4)
		else $error("four-phase order broken");
	a_nop_length: assert property (
		state_reg == ST_Q4 && skip_next && !NEXT_TWO_WORD |=> flush_reg [*4] ##1 !flush_reg && done_reg)
		else $error("one-word skip length wrong");

	c_bit_set: cover property (state_reg == ST_Q4 && rf_req_reg.wr_en);
	c_skip_one: cover property (state_reg == ST_Q4 && skip_next && !NEXT_TWO_WORD);
	c_skip_two: cover property (state_reg == ST_Q4 && skip_next && NEXT_TWO_WORD);
	c_no_skip: cover property (state_reg == ST_Q4 && instr_reg.opc != OPC_BIT_SET && !skip_next);
endmodule

// File: dv/bie_rf_model.sv
`timescale 1ns/100ps
module bie_rf_model import bie_pkg::*; (
	input wire logic SYS_CLK, // core clock
	input wire logic CLK_EN, // clock enable
	input wire bie_rf_req_t RF_REQ, // request from the core
	output logic [7:0] RF_RDATA // read data
);
	logic [7:0] mem [0:4095];
	// preset so every address holds a known byte
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i * 53 + 7);
		end
	end
	// valid only while reading, inverted otherwise so stale data never passes
	assign RF_RDATA = RF_REQ.rd_en ? mem[RF_REQ.addr] : ~mem[RF_REQ.addr];
	// byte write on enabled edges
	always @(posedge SYS_CLK) begin
		if (CLK_EN && RF_REQ.wr_en) begin
			mem[RF_REQ.addr] <= RF_REQ.wdata;
		end
	end
endmodule

// File: dv/bit_oriented_instruction_exec_test.sv
`timescale 1ns/100ps
module bit_oriented_instruction_exec_test import bie_pkg::*;;
	logic SYS_CLK, SYS_RST, CLK_EN, INSTR_VALID, NEXT_TWO_WORD, EXT_EN, FLUSH, BUSY, DONE, rnd_en, m_wr;
	bie_instr_t INSTR;
	bie_rf_req_t RF_REQ;
	logic [3:0] BANK_SEL, m_fl, m_nb;
	logic [11:0] IDX_BASE, m_addr;
	logic [7:0] RF_RDATA, m_data;
	logic [28:0] exp_q[$];
	int errors = 0;
	int n_tests = 0;
	bie_exec u_bie_exec(.SYS_CLK, .SYS_RST, .CLK_EN, .INSTR_VALID, .INSTR, .NEXT_TWO_WORD, .BANK_SEL,
		.EXT_EN, .IDX_BASE, .RF_RDATA, .RF_REQ, .FLUSH, .BUSY, .DONE);
	bie_rf_model u_bie_rf_model(.SYS_CLK, .CLK_EN, .RF_REQ, .RF_RDATA);
	// clock, 40 ns period
	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	// clock enable, random stalls when asked
	always @(posedge SYS_CLK) begin
		CLK_EN <= rnd_en ? 1'($urandom % 4 != 0) : 1'b1;
	end
	task automatic check(input logic [28:0] seen, input logic [28:0] expv);
		n_tests++;
		if (seen !== expv) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// monitor: collect one instruction's activity, compare at done
	always @(posedge SYS_CLK) begin
		if (SYS_RST || (DONE && CLK_EN)) begin
			if (!SYS_RST && exp_q.size() == 0) begin
				check(29'h1, 29'h0);
			end else if (!SYS_RST) begin
				check({m_addr, m_wr, m_data, m_fl, m_nb}, exp_q.pop_front());
			end
			m_wr = 1'b0;
			m_data = 8'h00;
			m_fl = 4'h0;
			m_nb = 4'h0;
		end else begin
			if (RF_REQ.rd_en) begin
				m_addr = RF_REQ.addr;
			end
			if (RF_REQ.wr_en) begin
				m_wr = 1'b1;
				m_data = RF_REQ.wdata;
			end
			m_fl = m_fl + 4'(FLUSH && CLK_EN);
			m_nb = m_nb + 4'(BUSY && CLK_EN);
		end
	end
	// one random instruction of the given kind, noted then offered
	task automatic issue(input logic [3:0] opc);
		bie_instr_t ins;
		logic [11:0] a, ib;
		logic [7:0] v;
		logic [3:0] bs, nf;
		logic ex, tw, sk, st;
		int n;
		ins = bie_instr_t'({opc, 12'($urandom)});
		bs = 4'($urandom);
		ex = 1'($urandom);
		ib = 12'($urandom);
		tw = 1'($urandom);
		if (ins.bank_flag) a = {bs, ins.f};
		else if (ins.f > IDX_LIMIT) a = {ACC_HIGH_BANK, ins.f};
		else if (ex) a = ib + 12'(ins.f);
		else a = {ACC_LOW_BANK, ins.f};
		v = u_bie_rf_model.mem[a];
		sk = opc == OPC_SKIP_CLEAR ? !v[ins.bit_idx] : opc == OPC_SKIP_SET && v[ins.bit_idx];
		nf = sk ? (tw ? 4'h8 : 4'h4) : 4'h0;
		st = opc == OPC_BIT_SET;
		exp_q.push_back({a, st, st ? v | 8'(1 << ins.bit_idx) : 8'h00, nf, 4'h4 + nf});
		BANK_SEL <= bs;
		EXT_EN <= ex;
		IDX_BASE <= ib;
		NEXT_TWO_WORD <= tw;
		INSTR <= ins;
		INSTR_VALID <= 1'b1;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
			if (n > 100) begin
				errors++;
				print_verdict();
			end
		end while (CLK_EN !== 1'b1);
		INSTR <= bie_instr_t'({4'h9, ins[11:0]});
		n = 0;
		while (DONE !== 1'b1 || CLK_EN !== 1'b1) begin
			n++;
			if (n > 100) begin
				errors++;
				print_verdict();
			end
			@(posedge SYS_CLK);
		end
	endtask
	// main sequence
	initial begin
		SYS_RST = 1'b1;
		INSTR_VALID = 1'b0;
		INSTR = '0;
		NEXT_TWO_WORD = 1'b0;
		BANK_SEL = 4'h0;
		EXT_EN = 1'b0;
		IDX_BASE = 12'h000;
		rnd_en = 1'b0;
		void'($urandom(32'h9d54bde3));
		repeat (6) @(posedge SYS_CLK);
		check({3'h0, RF_REQ, FLUSH, BUSY, DONE}, 29'h0);
		SYS_RST <= 1'b0;
		INSTR <= bie_instr_t'(16'h5ABC);
		INSTR_VALID <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		check({28'h0, BUSY}, 29'h0);
		$display("test unknown opcode done");
		for (int k = 0; k < 120; k++) begin
			rnd_en <= k >= 60;
			issue(k % 3 == 0 ? OPC_BIT_SET : k % 3 == 1 ? OPC_SKIP_CLEAR : OPC_SKIP_SET);
		end
		$display("test random instructions done");
		repeat (2) @(posedge SYS_CLK);
		check(29'(exp_q.size()), 29'h0);
		print_verdict();
	end
endmodule
